// File: ahbi_map.vh
// Constants of the ADC host bus port: register fields, reset values and
// conversion timing in enable-clock cycles.
// Assumes inclusion by the sequencer and top design files of the block.
`ifndef AHBI_MAP_VH
`define AHBI_MAP_VH

// ------------------------------------------------------------
// Register choice codes
// ------------------------------------------------------------
`define AHBI_SEL_ANALOG       1'b0
`define AHBI_SEL_CONTROL      1'b1
`define AHBI_SEL_DIGITAL      1'b1

// ------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------
`define AHBI_CTL_CHAN_HI      3
`define AHBI_CTL_CHAN_LO      0
`define AHBI_CTL_DIO_HI       6
`define AHBI_CTL_DIO_LO       4
`define AHBI_CTL_PORT_DIRECTION_BIT         7
`define AHBI_CTL_SC           8
`define AHBI_CTL_IE           14

// ------------------------------------------------------------
// Analog result and digital state register fields
// ------------------------------------------------------------
`define AHBI_ANA_EOC          15
`define AHBI_DIG_DIO_HI       2
`define AHBI_DIG_DIO_LO       0
`define AHBI_DIG_DI_HI        5
`define AHBI_DIG_DI_LO        3
`define AHBI_DIG_CHAN_HI      9
`define AHBI_DIG_CHAN_LO      6
`define AHBI_DIG_SH_HI        15
`define AHBI_DIG_SH_LO        10

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define AHBI_CHAN_RST         4'h0
`define AHBI_DIO_RST          3'h0
`define AHBI_BYTE_RST         8'h00

// ------------------------------------------------------------
// Conversion timing in enable-clock cycles
// ------------------------------------------------------------
`define AHBI_CONV_CYCLES      6'h20
`define AHBI_HOLD_CYCLE       6'h0d

`endif

// File: ahbi_edge.v
// Edge finder for the enable clock pin.
// Assumes the enable clock is synchronous to clk and far slower.
`timescale 1ns/1ps
module ahbi_edge
(
    input  wire clk,
    input  wire rstn,
    input  wire e_clk,
    output wire e_rise,
    output wire e_fall,
    output wire e_high
);

    reg e_prev_reg;

    // ------------------------------------------------------------
    // Previous level of the enable clock
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        if (!rstn)
            e_prev_reg <= 1'b0;
        else
            e_prev_reg <= e_clk;
    end

    assign e_rise = e_clk & ~e_prev_reg;
    assign e_fall = ~e_clk & e_prev_reg;
    assign e_high = e_clk & e_prev_reg;

endmodule

// File: ahbi_conv.v
// Conversion sequencer: counts enable-clock cycles from a start request,
// opens the sample switch and flags the result latch point.
// Assumes start arrives as a one-cycle pulse on a falling enable edge.
`timescale 1ns/1ps
`include "ahbi_map.vh"
module ahbi_conv
(
    input  wire       clk,
    input  wire       rstn,
    input  wire       e_rise,
    input  wire       start,
    output reg        busy_reg,
    output reg        hold_reg,
    output wire       done
);

    reg  [5:0] cnt_reg;

    assign done = busy_reg & e_rise & (cnt_reg == `AHBI_CONV_CYCLES - 6'h01);

    // ------------------------------------------------------------
    // Cycle counter
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        if (!rstn)
        begin
            busy_reg <= 1'b0;
            hold_reg <= 1'b0;
            cnt_reg  <= 6'h00;
        end
        else if (start)
        begin
            busy_reg <= 1'b1;
            hold_reg <= 1'b0;
            cnt_reg  <= 6'h00;
        end
        else if (busy_reg && e_rise)
        begin
            cnt_reg <= cnt_reg + 6'h01;
            // Input held on the array from cycle 13 on
            if (cnt_reg + 6'h01 == `AHBI_HOLD_CYCLE)
                hold_reg <= 1'b1;
            if (done)
            begin
                busy_reg <= 1'b0;
                hold_reg <= 1'b0;
            end
        end
    end

endmodule

// File: ahbi_top.v
// Processor bus port of a 16-channel ADC: select and direction decode,
// byte pointer, control register, result and pin state registers,
// 3-bit port and channel multiplexer selection.
// Assumes all pins synchronous to clk; the enable clock is sampled.
// What this block does
// - Data bus driven only during data reads
// - Write with register choice 1 fills control, read returns data
// - Reset clears start, irq, direction, status, channel
// - Reset keeps held conversion result
// - Reset floats data bus and port
// - Reset points byte pointer at MS byte
// - No transfer unless device selected
// - Shared pins always readable as digital bits
// - Port input after reset, output when set
// - Port updates at last falling edge
// - Dedicated input pins readable in digital register
// - Three 16-bit registers, MS and LS bytes
// - Pointer MS first, then LS while selected
// - Pointer returns after first deselected cycle
// - Single cycle reaches MS byte only
// - Decode select, direction and register choice
// - Multiplexer routes one of sixteen inputs
// - Any control write clears status flag
// - Result latched at enable cycle 32
// - Control write takes two enable cycles
// - Code 1 selects reference, others channels
`timescale 1ns/1ps
`include "ahbi_map.vh"
module ahbi_top
(
    input  wire        clk,
    input  wire        rstn,
    input  wire        e_clk,
    input  wire        sel_n,
    input  wire        rd_wr,
    input  wire        register_choice,
    input  wire [7:0]  data_in,
    output reg  [7:0]  data_out_reg,
    output reg         data_oe_reg,
    input  wire [2:0]  bidir_port_pins_in,
    output reg  [2:0]  bidir_port_pins_out_reg,
    output reg         bidir_port_pins_oe_reg,
    input  wire [2:0]  fixed_input_pins,
    input  wire [5:0]  shared_input_pins,
    input  wire        irq_n_in,
    output reg         irq_n_out_reg,
    output reg         irq_n_oe_reg,
    input  wire [7:0]  adc_code,
    output reg  [15:0] mux_select_reg,
    output reg         sample_hold_reg
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    wire        e_rise;
    wire        e_fall;
    wire        e_high;
    wire        conv_busy;
    wire        conv_hold;
    wire        conv_done;
    wire        selected;
    wire        ctl_access;
    wire        rd_access;
    wire [15:0] analog_result;
    wire [15:0] digital_pin_state;
    wire [15:0] rd_word;

    reg         byte_ptr_reg;
    reg         byte_ptr_next;
    reg  [3:0]  channel_address_field_reg;
    reg  [2:0]  dio_value_reg;
    reg         port_direction_bit_reg;
    reg         conversion_start_bit_reg;
    reg         irq_enable_bit_reg;
    reg         eoc_reg;
    reg  [7:0]  result_reg;
    reg  [7:0]  ctl_ms_reg;
    reg         ctl_second_reg;
    reg         start_pend_reg;
    reg         conv_start_reg;
    reg         irq_pend_reg;
    reg  [15:0] mux_select_next;

    // ------------------------------------------------------------
    // Enable clock edges and conversion sequencer
    // ------------------------------------------------------------
    ahbi_edge u_edge
    (
        .clk    (clk),
        .rstn   (rstn),
        .e_clk  (e_clk),
        .e_rise (e_rise),
        .e_fall (e_fall),
        .e_high (e_high)
    );

    // Sequencer counts on rising enable edges only
    ahbi_conv u_conv
    (
        .clk      (clk),
        .rstn     (rstn),
        .e_rise   (e_rise),
        .start    (conv_start_reg),
        .busy_reg (conv_busy),
        .hold_reg (conv_hold),
        .done     (conv_done)
    );

    // ------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------
    assign selected   = ~sel_n;
    assign ctl_access = selected & ~rd_wr & (register_choice == `AHBI_SEL_CONTROL);
    assign rd_access  = selected & rd_wr;

    // ------------------------------------------------------------
    // Readable registers
    // ------------------------------------------------------------
    // Status bit stays low while a conversion runs
    assign analog_result = {eoc_reg, 7'h00, result_reg};

    assign digital_pin_state = {shared_input_pins,
                                channel_address_field_reg,
                                fixed_input_pins,
                                bidir_port_pins_in};

    assign rd_word = (register_choice == `AHBI_SEL_DIGITAL) ? digital_pin_state
                                                          : analog_result;

    // ------------------------------------------------------------
    // Byte pointer
    // ------------------------------------------------------------
    always @*
    begin
        byte_ptr_next = byte_ptr_reg;
        // MS first; LS while selected; back after a deselected cycle
        if (e_fall)
            byte_ptr_next = selected;
    end

    always @(posedge clk)
    begin
        if (!rstn)
            byte_ptr_reg <= 1'b0;
        else
            byte_ptr_reg <= byte_ptr_next;
    end

    // ------------------------------------------------------------
    // Read data drive
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        if (!rstn)
        begin
            data_oe_reg  <= 1'b0;
            data_out_reg <= `AHBI_BYTE_RST;
        end
        else
        begin
            // Driven only while a read is selected and E is high
            data_oe_reg <= rd_access & e_high;
            if (rd_access && e_high)
            begin
                if (byte_ptr_reg)
                    data_out_reg <= rd_word[7:0];
                else
                    data_out_reg <= rd_word[15:8];
            end
        end
    end

    // ------------------------------------------------------------
    // Control register writes
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        if (!rstn)
        begin
            channel_address_field_reg <= `AHBI_CHAN_RST;
            dio_value_reg             <= `AHBI_DIO_RST;
            port_direction_bit_reg    <= 1'b0;
            conversion_start_bit_reg  <= 1'b0;
            irq_enable_bit_reg        <= 1'b0;
            ctl_ms_reg                <= `AHBI_BYTE_RST;
            ctl_second_reg            <= 1'b0;
            start_pend_reg            <= 1'b0;
            conv_start_reg            <= 1'b0;
        end
        else
        begin
            conv_start_reg <= 1'b0;
            if (e_fall)
            begin
                ctl_second_reg <= 1'b0;
                if (ctl_access && !byte_ptr_reg)
                begin
                    // MS byte: interrupt enable takes effect; start is held pending
                    ctl_ms_reg               <= data_in;
                    conversion_start_bit_reg <= data_in[`AHBI_CTL_SC - 8];
                    irq_enable_bit_reg       <= data_in[`AHBI_CTL_IE - 8];
                    start_pend_reg           <= data_in[`AHBI_CTL_SC - 8];
                    ctl_second_reg           <= 1'b1;
                end
                else if (ctl_second_reg)
                begin
                    // Second cycle of every write; start follows it
                    start_pend_reg <= 1'b0;
                    conv_start_reg <= start_pend_reg;
                    if (ctl_access && byte_ptr_reg)
                    begin
                        // LS byte only in the second cycle of a 16-bit write
                        channel_address_field_reg <= data_in[`AHBI_CTL_CHAN_HI:`AHBI_CTL_CHAN_LO];
                        dio_value_reg             <= data_in[`AHBI_CTL_DIO_HI:`AHBI_CTL_DIO_LO];
                        port_direction_bit_reg    <= data_in[`AHBI_CTL_PORT_DIRECTION_BIT];
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Conversion result and status
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        // Result survives reset
        if (conv_done)
            result_reg <= adc_code;
    end

    always @(posedge clk)
    begin
        if (!rstn)
        begin
            eoc_reg      <= 1'b0;
            irq_pend_reg <= 1'b0;
        end
        else if (conv_done)
        begin
            // Set wins over a clear in the same cycle
            eoc_reg      <= 1'b1;
            irq_pend_reg <= irq_enable_bit_reg;
        end
        else if (e_fall && ctl_access && !byte_ptr_reg)
        begin
            eoc_reg      <= 1'b0;
            irq_pend_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Interrupt pin, open drain
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        if (!rstn)
        begin
            irq_n_out_reg <= 1'b0;
            irq_n_oe_reg  <= 1'b0;
        end
        else
        begin
            irq_n_out_reg <= 1'b0;
            irq_n_oe_reg  <= irq_pend_reg & irq_enable_bit_reg;
        end
    end

    // ------------------------------------------------------------
    // 3-bit port drive
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        if (!rstn)
        begin
            bidir_port_pins_oe_reg  <= 1'b0;
            bidir_port_pins_out_reg <= `AHBI_DIO_RST;
        end
        else
        begin
            bidir_port_pins_oe_reg  <= port_direction_bit_reg;
            bidir_port_pins_out_reg <= dio_value_reg;
        end
    end

    // ------------------------------------------------------------
    // Channel multiplexer select
    // ------------------------------------------------------------
    always @*
    begin
        // One-hot; line 1 is the reference input
        mux_select_next = 16'h0000;
        mux_select_next[channel_address_field_reg] = 1'b1;
    end

    always @(posedge clk)
    begin
        if (!rstn)
        begin
            mux_select_reg  <= 16'h0001;
            sample_hold_reg <= 1'b0;
        end
        else
        begin
            mux_select_reg  <= mux_select_next;
            sample_hold_reg <= conv_hold;
        end
    end

endmodule

// File: ahbi_top_monitor.sv
// Checker of the host bus port outputs.
// Assumes it is bound into ahbi_top and sees only its ports.
`timescale 1ns/1ps
module ahbi_top_monitor
(
    input wire        clk,
    input wire        rstn,
    input wire        e_clk,
    input wire        sel_n,
    input wire        rd_wr,
    input wire        register_choice,
    input wire        data_oe_reg,
    input wire [2:0]  bidir_port_pins_out_reg,
    input wire        bidir_port_pins_oe_reg,
    input wire        irq_n_oe_reg,
    input wire [15:0] mux_select_reg,
    input wire        sample_hold_reg
);
default clocking @(posedge clk); endclocking
default disable iff (!rstn);
wire ctl_wr = !sel_n && !rd_wr && register_choice;
// ----------------------------------------
// Properties
// ----------------------------------------
property p_oe_read;
    data_oe_reg |-> !$past(sel_n, 2) && $past(rd_wr, 2);
endproperty
a_oe_read: assert property (p_oe_read) else $error("bus driven outside a read");
property p_rst;
    $rose(rstn) |-> mux_select_reg == 16'h0001 && !data_oe_reg && !bidir_port_pins_oe_reg && !irq_n_oe_reg;
endproperty
a_rst: assert property (p_rst) else $error("outputs not in reset state");
property p_onehot;
    $onehot(mux_select_reg);
endproperty
a_onehot: assert property (p_onehot) else $error("channel select not one-hot");
property p_mux_wr;
    $changed(mux_select_reg) |-> $past(ctl_wr, 1);
endproperty
a_mux_wr: assert property (p_mux_wr) else $error("channel changed without write");
property p_port_wr;
    $changed(bidir_port_pins_out_reg) || $rose(bidir_port_pins_oe_reg) |-> $past(ctl_wr, 1);
endproperty
a_port_wr: assert property (p_port_wr) else $error("port changed without write");
property p_oe_e;
    $rose(data_oe_reg) |-> $past(e_clk, 1) && e_clk;
endproperty
a_oe_e: assert property (p_oe_e) else $error("bus driven while enable low");
property p_oe_drop;
    $fell(e_clk) |-> ##[0:3] !data_oe_reg;
endproperty
a_oe_drop: assert property (p_oe_drop) else $error("bus still driven after enable fall");
property p_hold;
    $rose(sample_hold_reg) |-> sample_hold_reg [*8];
endproperty
a_hold: assert property (p_hold) else $error("hold window too short");
c_read: cover property (data_oe_reg);
c_port: cover property ($rose(bidir_port_pins_oe_reg));
c_irq: cover property ($rose(irq_n_oe_reg));
endmodule
bind ahbi_top ahbi_top_monitor i_mon (.clk(clk), .rstn(rstn), .e_clk(e_clk), .sel_n(sel_n), .rd_wr(rd_wr),
    .register_choice(register_choice), .data_oe_reg(data_oe_reg),
    .bidir_port_pins_out_reg(bidir_port_pins_out_reg), .bidir_port_pins_oe_reg(bidir_port_pins_oe_reg),
    .irq_n_oe_reg(irq_n_oe_reg), .mux_select_reg(mux_select_reg), .sample_hold_reg(sample_hold_reg));

// File: ahbi_cpu_model.sv
// Bus master model: one enable-clock cycle per call of cycle.
// Assumes the bench keeps calling it so the enable clock never stops.
`timescale 1ns/1ps
module ahbi_cpu_model
#(
    parameter HALF = 8
)
(
    input  wire       clk,
    output reg        e_clk,
    output reg        sel_n,
    output reg        rd_wr,
    output reg        register_choice,
    output reg  [7:0] data_in
);
initial
begin
    e_clk = 1'b0;
    sel_n = 1'b1;
    rd_wr = 1'b1;
    register_choice = 1'b0;
    data_in = 8'h00;
end
// ----------------------------------------
// Setup, low phase, high phase, hold
// ----------------------------------------
task cycle(input logic s_n, input logic rw, input logic rs, input logic [7:0] d);
    begin
        @(posedge clk);
        #1;
        sel_n = s_n;
        rd_wr = rw;
        register_choice = rs;
        data_in = (s_n || rw) ? ~data_in : d;
        repeat (HALF) @(posedge clk);
        #1;
        e_clk = 1'b1;
        repeat (HALF) @(posedge clk);
        #1;
        e_clk = 1'b0;
        repeat (3) @(posedge clk);
    end
endtask
endmodule

// File: adc_host_bus_interface_tb.sv
// Self-checking bench of the ADC host bus port.
// Assumes the design, the checker and the bus master model are compiled first.
`timescale 1ns/1ps
module adc_host_bus_interface_tb;
reg         clk;
reg         rstn;
reg  [2:0]  ext_port;
reg  [2:0]  fixed_pins;
reg  [5:0]  shared_pins;
reg  [7:0]  adc;
reg  [2:0]  dio;
wire        e_clk;
wire        sel_n;
wire        rd_wr;
wire        rs;
wire [7:0]  d_in;
wire [7:0]  d_out;
wire        d_oe;
wire [2:0]  port_out;
wire        port_oe;
wire        irq_out;
wire        irq_oe;
wire [15:0] mux_sel;
wire        hold;
wire [2:0]  port_pins = port_oe ? port_out : ext_port;
logic [7:0] exp_q[$];
integer     fails;
integer     n_tests;
integer     c;
ahbi_cpu_model i_cpu (.clk(clk), .e_clk(e_clk), .sel_n(sel_n), .rd_wr(rd_wr), .register_choice(rs),
    .data_in(d_in));
ahbi_top i_dut (.clk(clk), .rstn(rstn), .e_clk(e_clk), .sel_n(sel_n), .rd_wr(rd_wr), .register_choice(rs),
    .data_in(d_in), .data_out_reg(d_out), .data_oe_reg(d_oe), .bidir_port_pins_in(port_pins),
    .bidir_port_pins_out_reg(port_out), .bidir_port_pins_oe_reg(port_oe), .fixed_input_pins(fixed_pins),
    .shared_input_pins(shared_pins), .irq_n_in(~irq_oe), .irq_n_out_reg(irq_out), .irq_n_oe_reg(irq_oe),
    .adc_code(adc), .mux_select_reg(mux_sel), .sample_hold_reg(hold));
initial clk = 1'b0;
always #2.5 clk = ~clk;
// ----------------------------------------
// Tasks
// ----------------------------------------
task chk(input logic [15:0] got, input logic [15:0] exp);
    begin
        n_tests = n_tests + 1;
        if (got !== exp)
        begin
            fails = fails + 1;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    end
endtask
task print_verdict;
    begin
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    end
endtask
task idle(input integer n);
    repeat (n) i_cpu.cycle(1'b1, 1'b1, 1'b0, 8'h00);
endtask
task wr(input logic rs_v, input logic [15:0] v, input integer n);
    begin
        i_cpu.cycle(1'b0, 1'b0, rs_v, v[15:8]);
        if (n == 2)
            i_cpu.cycle(1'b0, 1'b0, rs_v, v[7:0]);
        idle(1);
    end
endtask
task rd(input logic rs_v, input logic [15:0] v, input integer n);
    integer i;
    begin
        for (i = 0; i < n; i = i + 1)
        begin
            exp_q.push_back(i == 0 ? v[15:8] : v[7:0]);
            i_cpu.cycle(1'b0, 1'b1, rs_v, 8'h00);
        end
        idle(1);
    end
endtask
function [15:0] dig_exp(input [3:0] ch);
    dig_exp = {shared_pins, ch, fixed_pins, port_pins};
endfunction
// Read results are compared at each enable fall
always @(negedge e_clk)
begin
    if (!sel_n && rd_wr)
    begin
        if (exp_q.size() == 0)
            chk(16'hffff, 16'h0000);
        else
            chk({7'h00, d_oe, d_out}, {8'h01, exp_q.pop_front()});
    end
end
initial
begin
    #100000;
    fails = fails + 1;
    print_verdict;
end
// ----------------------------------------
// Main sequence
// ----------------------------------------
initial
begin
    fails = 0;
    n_tests = 0;
    rstn = 1'b0;
    void'($urandom(96));
    ext_port = $urandom;
    fixed_pins = $urandom;
    shared_pins = $urandom;
    adc = 8'h00;
    idle(1);
    #1 rstn = 1'b1;
    chk(mux_sel, 16'h0001);
    chk({13'h0000, port_oe, d_oe, irq_oe}, 16'h0000);
    rd(1'b1, dig_exp(4'h0), 2);
    for (c = 0; c < 16; c = c + 1)
    begin
        dio = $urandom;
        wr(1'b1, {8'h00, c[0], dio, c[3:0]}, 2);
        chk(mux_sel, 16'h0001 << c);
        chk({12'h000, port_oe, port_out}, {12'h000, c[0], dio});
        rd(1'b1, dig_exp(c[3:0]), 2);
    end
    wr(1'b0, 16'h0002, 2);
    i_cpu.cycle(1'b1, 1'b0, 1'b1, 8'h00);
    chk(mux_sel, 16'h8000);
    #1 adc = $urandom;
    wr(1'b1, 16'h0185, 2);
    rd(1'b0, 16'h0000, 1);
    rd(1'b0, 16'h0000, 1);
    idle(32);
    rd(1'b0, {8'h80, adc}, 2);
    wr(1'b1, 16'h4100, 1);
    rd(1'b0, 16'h0000, 1);
    chk(mux_sel, 16'h0020);
    #1 adc = $urandom;
    idle(14);
    chk({15'h0000, hold}, 16'h0001);
    idle(20);
    chk({14'h0000, irq_out, irq_oe}, 16'h0001);
    chk({15'h0000, hold}, 16'h0000);
    rd(1'b0, {8'h80, adc}, 2);
    #1 rstn = 1'b0;
    idle(1);
    #1 rstn = 1'b1;
    chk(mux_sel, 16'h0001);
    chk({13'h0000, port_oe, d_oe, irq_oe}, 16'h0000);
    rd(1'b0, {8'h00, adc}, 2);
    rd(1'b1, dig_exp(4'h0), 3);
    print_verdict;
end
endmodule
